// [rtl/tss_pkg.sv]
// shared constants for the thermal sensor register bank
package tss_pkg;
  // register pointer values
  localparam logic [2:0] TSS_PTR_FEATURE = 3'h0;
  localparam logic [2:0] TSS_PTR_CONTROL = 3'h1;
  localparam logic [2:0] TSS_PTR_UPPER = 3'h2;
  localparam logic [2:0] TSS_PTR_LOWER = 3'h3;
  localparam logic [2:0] TSS_PTR_OVERHEAT = 3'h4;
  localparam logic [2:0] TSS_PTR_TEMP = 3'h5;
  localparam logic [2:0] TSS_PTR_MAKER = 3'h6;
  localparam logic [2:0] TSS_PTR_PART = 3'h7;
  // reset values
  localparam logic [15:0] TSS_FEATURE_VALUE = 16'h0077;
  localparam logic [15:0] TSS_CONTROL_RESET = 16'h0000;
  localparam logic [10:0] TSS_LIMIT_RESET = 11'h000;
  localparam logic [12:0] TSS_TEMP_RESET = 13'h0000;
  localparam logic [2:0] TSS_PTR_RESET = TSS_PTR_FEATURE;
  // control register field positions
  localparam int TSS_CTL_MODE = 0;
  localparam int TSS_CTL_POL = 1;
  localparam int TSS_CTL_CRITONLY = 2;
  localparam int TSS_CTL_ENABLE = 3;
  localparam int TSS_CTL_STATUS = 4;
  localparam int TSS_CTL_CLEAR = 5;
  localparam int TSS_CTL_ALMLOCK = 6;
  localparam int TSS_CTL_CRITLOCK = 7;
  localparam int TSS_CTL_HALT = 8;
  localparam int TSS_CTL_TRIP_HYSTERESIS_SELECT_LO = 9;
  // hysteresis in 1/16 degree steps: off, 1.5, 3, 6
  localparam logic [12:0] TSS_TRIP_HYSTERESIS_SELECT_0 = 13'h0000;
  localparam logic [12:0] TSS_TRIP_HYSTERESIS_SELECT_1 = 13'h0018;
  localparam logic [12:0] TSS_TRIP_HYSTERESIS_SELECT_2 = 13'h0030;
  localparam logic [12:0] TSS_TRIP_HYSTERESIS_SELECT_3 = 13'h0060;
  // serial bus address preamble
  localparam logic [3:0] TSS_ADDR_PREAMBLE = 4'h3;
  // bus timeout: least time, clock period, derived count
  localparam int TSS_CLK_NS = 4;
  localparam int TSS_TIMEOUT_NS = 25000000;
  localparam int TSS_TIMEOUT_CYCLES = (TSS_TIMEOUT_NS + TSS_CLK_NS - 1) / TSS_CLK_NS;
  localparam logic [3:0] TSS_BIT_LAST = 4'h7;
  localparam logic [3:0] TSS_BIT_FULL = 4'h8;
  // serial engine states
  typedef enum logic [8:0] {
    TSS_IDLE = 9'h001,
    TSS_ADDR = 9'h002,
    TSS_ADDR_ACK = 9'h004,
    TSS_PTR = 9'h008,
    TSS_PTR_ACK = 9'h010,
    TSS_WDATA = 9'h020,
    TSS_WDATA_ACK = 9'h040,
    TSS_RDATA = 9'h080,
    TSS_RACK = 9'h100
  } tss_state_t;
endpackage

// [rtl/tss_pin_sync.sv]
// three-stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module tss_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinIn,
  input wire logic [WIDTH-1:0] resetValue,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1; // only stage2 reads this
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic primed; // first clean value after reset not yet taken

  // shift chain, reset to idle-high so the bus looks free
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per-bit agreement filter; a one-cycle glitch never reaches pinOut
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= '1;
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
      for (int i = 0; i < WIDTH; i++) begin
        if (!primed) begin
          pinOut[i] <= resetValue[i];
        end else if (stage2[i] == stage3[i]) begin
          pinOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule // tss_pin_sync

// [rtl/tss_bus_timeout.sv]
// clock-low watchdog that abandons a stuck serial transfer
`timescale 1ns/1ps
module tss_bus_timeout #(
  parameter int LIMIT = 6250000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic busActive,
  input wire logic sclLevel,
  output logic expired
);
  logic [31:0] lowCount; // cycles clock has been held low

  // count while a transfer is open and clock stays low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCount <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (!busActive || sclLevel) begin
      lowCount <= 32'h0000_0000;
      expired <= 1'b0;
    end else begin
      expired <= (lowCount == 32'(LIMIT - 1));
      if (lowCount != 32'(LIMIT)) begin
        lowCount <= lowCount + 32'h0000_0001;
      end
    end
  end
endmodule // tss_bus_timeout

// [rtl/tss_register_bank.sv]
// thermal sensor register bank with serial slave and alert pin logic
// How it works
// - eight 16-bit registers, defined power-on values
// - reserved bits ignore writes, read zero
// - feature bit 7 zero: halt freezes status
// - feature bit 6: bus timeout 25-35 ms
// - feature bits 4:3 give resolution code
// - feature bits 2:0 sign, accuracy, alerts
// - during halt clear works, nothing sets status
// - control bits 10:9 select trip hysteresis
// - halt stops temperature updates, holds value
// - halt not settable under lock; clears anytime
// - overheat lock freezes overheat limit, sticky
// - alarm lock freezes window limits, sticky
// - clear strobe self-clears, reads zero
// - clear ignored in comparator mode, deferred above overheat
// - status bit copies asserted alert, polarity-free
// - enable bit gates alert; off means inactive
// - overheat-only select limits alert sources
// - polarity bit sets asserted pin level
// - mode bit: comparator or interrupt
// - hysteresis, enable, polarity, mode locked
// - overheat-only cannot be set under alarm lock
// - limits two's complement, bits 12:2 stored
// - clear above overheat waits until below
// - temperature word: three trip flags, 13 bits
// - pointer starts at feature register
`timescale 1ns/1ps
module tss_register_bank
  import tss_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TSS_TIMEOUT_CYCLES,
  parameter logic [15:0] MAKER_CODE = 16'h5a5a, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0101 // arbitrary value
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] addrSel,
  input wire logic [12:0] sampleTemp,
  input wire logic sampleValid,
  output logic converterHalt,
  output logic alertOut,
  output logic alertOe
);
  logic scl, sda, sclPrev, sdaPrev; // filtered pins and last values
  logic [2:0] addrPins; // filtered address straps
  logic sclRise, sclFall, busStart, busStop, timedOut;
  tss_state_t state;
  logic [3:0] bitCnt; // bits moved in the current byte
  logic [7:0] rxShift, txShift;
  logic readMode, secondByte, writeArmed;
  logic [2:0] regPtr;
  logic [15:0] wrData; // staged two-byte write, committed at stop
  logic regWrite; // one-cycle commit pulse
  // control fields
  logic [1:0] hystSel;
  logic critLock, alarmLock, outEnable, critOnly, polHigh, intMode;
  logic statusFlag; // asserted alert before enable gating
  logic alertFlag; // readable copy, gated by enable
  logic clearPend; // clear taken while above overheat
  logic [10:0] upperLim, lowerLim, critLim;
  logic [12:0] tempVal;
  logic aboveCrit, aboveHigh, belowLow, windowPrev;
  logic [15:0] featureWord, controlWord, readWord;
  logic anyLock, clearReq, windowCond, condNow;
  logic [12:0] hystVal;

  tss_pin_sync #(.WIDTH(5)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pinIn({sclIn, sdaIn, addrSel}),
    .resetValue(5'h1f),
    .pinOut({scl, sda, addrPins})
  );

  tss_bus_timeout #(.LIMIT(TIMEOUT_CYCLES)) u_timeout (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .busActive(state != TSS_IDLE),
    .sclLevel(scl),
    .expired(timedOut)
  );

  // edge history of the filtered pins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sda;
    end
  end

  assign sclRise = scl && !sclPrev;
  assign sclFall = !scl && sclPrev;
  assign busStart = scl && sclPrev && sdaPrev && !sda;
  assign busStop = scl && sclPrev && !sdaPrev && sda;
  assign anyLock = critLock || alarmLock;

  // fixed capability word
  assign featureWord = TSS_FEATURE_VALUE;

  // control read view; clear strobe and reserved bits read zero
  assign controlWord = {5'h00, hystSel, converterHalt, critLock, alarmLock, 1'b0,
                        alertFlag, outEnable, critOnly, polHigh, intMode};

  // read multiplexer
  always_comb begin
    case (regPtr)
      TSS_PTR_FEATURE: readWord = featureWord;
      TSS_PTR_CONTROL: readWord = controlWord;
      TSS_PTR_UPPER: readWord = {3'h0, upperLim, 2'h0};
      TSS_PTR_LOWER: readWord = {3'h0, lowerLim, 2'h0};
      TSS_PTR_OVERHEAT: readWord = {3'h0, critLim, 2'h0};
      TSS_PTR_TEMP: readWord = {aboveCrit, aboveHigh, belowLow, tempVal};
      TSS_PTR_MAKER: readWord = MAKER_CODE;
      default: readWord = PART_CODE;
    endcase
  end

  // serial slave engine: address, pointer, two data bytes, reads
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= TSS_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      readMode <= 1'b0;
      secondByte <= 1'b0;
      writeArmed <= 1'b0;
      regPtr <= TSS_PTR_RESET;
      wrData <= 16'h0000;
      regWrite <= 1'b0;
      sdaOe <= 1'b0;
    end else begin
      regWrite <= 1'b0;
      if (busStop || timedOut) begin
        // a full two-byte write lands only at the stop
        regWrite <= busStop && writeArmed;
        writeArmed <= 1'b0;
        state <= TSS_IDLE;
        sdaOe <= 1'b0;
      end else if (busStart) begin
        state <= TSS_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
        writeArmed <= 1'b0;
      end else begin
        case (state)
          TSS_ADDR, TSS_PTR, TSS_WDATA: begin
            if (sclRise && bitCnt != TSS_BIT_FULL) begin
              rxShift <= {rxShift[6:0], sda};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == TSS_BIT_FULL) begin
              bitCnt <= 4'h0;
              if (state == TSS_ADDR) begin
                // answer only our own address
                if (rxShift[7:1] == {TSS_ADDR_PREAMBLE, addrPins}) begin
                  readMode <= rxShift[0];
                  sdaOe <= 1'b1;
                  state <= TSS_ADDR_ACK;
                end else begin
                  state <= TSS_IDLE;
                end
              end else if (state == TSS_PTR) begin
                regPtr <= rxShift[2:0];
                sdaOe <= 1'b1;
                state <= TSS_PTR_ACK;
              end else begin
                // every data byte is acknowledged, even if later refused
                if (!secondByte) begin
                  wrData[15:8] <= rxShift;
                end else begin
                  wrData[7:0] <= rxShift;
                  writeArmed <= 1'b1;
                end
                sdaOe <= 1'b1;
                state <= TSS_WDATA_ACK;
              end
            end
          end
          TSS_ADDR_ACK: begin
            if (sclFall) begin
              if (readMode) begin
                txShift <= readWord[15:8];
                sdaOe <= !readWord[15];
                secondByte <= 1'b0;
                state <= TSS_RDATA;
              end else begin
                sdaOe <= 1'b0;
                state <= TSS_PTR;
              end
            end
          end
          TSS_PTR_ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              secondByte <= 1'b0;
              state <= TSS_WDATA;
            end
          end
          TSS_WDATA_ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              secondByte <= !secondByte;
              state <= TSS_WDATA;
            end
          end
          TSS_RDATA: begin
            if (sclFall) begin
              if (bitCnt == TSS_BIT_LAST) begin
                bitCnt <= 4'h0;
                sdaOe <= 1'b0;
                state <= TSS_RACK;
              end else begin
                bitCnt <= bitCnt + 4'h1;
                txShift <= {txShift[6:0], 1'b0};
                sdaOe <= !txShift[6];
              end
            end
          end
          TSS_RACK: begin
            // master answers; no-ack ends the read
            if (sclRise && sda) begin
              state <= TSS_IDLE;
            end else if (sclFall) begin
              secondByte <= !secondByte;
              txShift <= secondByte ? readWord[15:8] : readWord[7:0];
              sdaOe <= secondByte ? !readWord[15] : !readWord[7];
              state <= TSS_RDATA;
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // constant low data level; the pin is open-drain via sdaOe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOut <= 1'b0;
      alertOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      alertOut <= 1'b0;
    end
  end

  // control writes: locks sticky, locked fields refuse changes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hystSel <= TSS_CONTROL_RESET[10:9];
      converterHalt <= TSS_CONTROL_RESET[TSS_CTL_HALT];
      critLock <= TSS_CONTROL_RESET[TSS_CTL_CRITLOCK];
      alarmLock <= TSS_CONTROL_RESET[TSS_CTL_ALMLOCK];
      outEnable <= TSS_CONTROL_RESET[TSS_CTL_ENABLE];
      critOnly <= TSS_CONTROL_RESET[TSS_CTL_CRITONLY];
      polHigh <= TSS_CONTROL_RESET[TSS_CTL_POL];
      intMode <= TSS_CONTROL_RESET[TSS_CTL_MODE];
    end else if (regWrite && regPtr == TSS_PTR_CONTROL) begin
      critLock <= critLock || wrData[TSS_CTL_CRITLOCK];
      alarmLock <= alarmLock || wrData[TSS_CTL_ALMLOCK];
      if (!anyLock) begin
        hystSel <= wrData[TSS_CTL_TRIP_HYSTERESIS_SELECT_LO +: 2];
        outEnable <= wrData[TSS_CTL_ENABLE];
        polHigh <= wrData[TSS_CTL_POL];
        intMode <= wrData[TSS_CTL_MODE];
      end
      // halt may always be cleared, set only when unlocked
      if (!wrData[TSS_CTL_HALT] || !anyLock) begin
        converterHalt <= wrData[TSS_CTL_HALT];
      end
      if (!wrData[TSS_CTL_CRITONLY] || !alarmLock) begin
        critOnly <= wrData[TSS_CTL_CRITONLY];
      end
    end
  end

  // limit registers; refused writes leave contents as they were
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      upperLim <= TSS_LIMIT_RESET;
      lowerLim <= TSS_LIMIT_RESET;
      critLim <= TSS_LIMIT_RESET;
    end else if (regWrite) begin
      if (regPtr == TSS_PTR_UPPER && !alarmLock) begin
        upperLim <= wrData[12:2];
      end
      if (regPtr == TSS_PTR_LOWER && !alarmLock) begin
        lowerLim <= wrData[12:2];
      end
      if (regPtr == TSS_PTR_OVERHEAT && !critLock) begin
        critLim <= wrData[12:2];
      end
    end
  end

  // temperature capture, frozen while the converter is halted
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tempVal <= TSS_TEMP_RESET;
    end else if (sampleValid && !converterHalt) begin
      tempVal <= sampleTemp;
    end
  end

  // hysteresis amount in sixteenths of a degree
  always_comb begin
    case (hystSel)
      2'h0: hystVal = TSS_TRIP_HYSTERESIS_SELECT_0;
      2'h1: hystVal = TSS_TRIP_HYSTERESIS_SELECT_1;
      2'h2: hystVal = TSS_TRIP_HYSTERESIS_SELECT_2;
      default: hystVal = TSS_TRIP_HYSTERESIS_SELECT_3;
    endcase
  end

  // trip flags with hysteresis; limits are widened to temperature scale
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aboveCrit <= 1'b0;
      aboveHigh <= 1'b0;
      belowLow <= 1'b0;
    end else if (!converterHalt) begin
      // flags also react straight away to limit changes
      if ($signed(tempVal) > $signed({critLim, 2'h0})) begin
        aboveCrit <= 1'b1;
      end else if ($signed(tempVal) <= $signed(13'({critLim, 2'h0} - hystVal))) begin
        aboveCrit <= 1'b0;
      end
      if ($signed(tempVal) > $signed({upperLim, 2'h0})) begin
        aboveHigh <= 1'b1;
      end else if ($signed(tempVal) <= $signed(13'({upperLim, 2'h0} - hystVal))) begin
        aboveHigh <= 1'b0;
      end
      if ($signed(tempVal) < $signed({lowerLim, 2'h0})) begin
        belowLow <= 1'b1;
      end else if ($signed(tempVal) >= $signed(13'({lowerLim, 2'h0} + hystVal))) begin
        belowLow <= 1'b0;
      end
    end
  end

  assign windowCond = !critOnly && (aboveHigh || belowLow);
  assign condNow = aboveCrit || windowCond;
  assign clearReq = regWrite && regPtr == TSS_PTR_CONTROL && wrData[TSS_CTL_CLEAR];

  // alert status: comparator follows, interrupt latches crossings
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      statusFlag <= 1'b0;
      clearPend <= 1'b0;
      windowPrev <= 1'b0;
    end else begin
      windowPrev <= windowCond;
      if (!intMode) begin
        // clear requests have no effect here
        clearPend <= 1'b0;
        if (!converterHalt) begin
          statusFlag <= condNow;
        end
      end else if (!converterHalt && (aboveCrit || windowCond != windowPrev)) begin
        // a new event beats a clear in the same cycle
        statusFlag <= 1'b1;
        clearPend <= clearPend || (clearReq && aboveCrit);
      end else if (clearReq || (clearPend && !aboveCrit)) begin
        // halted: clear still works, nothing sets the flag
        statusFlag <= 1'b0;
        clearPend <= 1'b0;
      end
    end
  end

  // pin drive: asserted level per polarity, inactive when disabled
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      alertFlag <= 1'b0;
      alertOe <= 1'b0;
    end else begin
      alertFlag <= outEnable && statusFlag;
      alertOe <= polHigh ? !(outEnable && statusFlag) : (outEnable && statusFlag);
    end
  end

  property p_feature_const;
    @(posedge mclk) disable iff (sys_rst)
      regPtr == TSS_PTR_FEATURE |-> readWord == TSS_FEATURE_VALUE;
  endproperty
  a_feature_const: assert property (p_feature_const) else $error("feature word wrong");

  property p_reserved_zero;
    @(posedge mclk) disable iff (sys_rst)
      regPtr == TSS_PTR_CONTROL |-> readWord[15:11] == 5'h00 && !readWord[TSS_CTL_CLEAR];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_crit_lock_sticky;
    @(posedge mclk) disable iff (sys_rst) critLock |=> critLock;
  endproperty
  a_crit_lock_sticky: assert property (p_crit_lock_sticky) else $error("lock dropped");

  property p_crit_lim_frozen;
    @(posedge mclk) disable iff (sys_rst)
      critLock && regWrite && regPtr == TSS_PTR_OVERHEAT |=> $stable(critLim);
  endproperty
  a_crit_lim_frozen: assert property (p_crit_lim_frozen) else $error("locked limit changed");

  property p_alarm_lim_frozen;
    @(posedge mclk) disable iff (sys_rst)
      alarmLock |=> $stable(upperLim) && $stable(lowerLim);
  endproperty
  a_alarm_lim_frozen: assert property (p_alarm_lim_frozen) else $error("window changed");

  property p_halt_lock;
    @(posedge mclk) disable iff (sys_rst) anyLock && !converterHalt |=> !converterHalt;
  endproperty
  a_halt_lock: assert property (p_halt_lock) else $error("halt set under lock");

  property p_temp_hold;
    @(posedge mclk) disable iff (sys_rst) converterHalt |=> $stable(tempVal);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temp moved in halt");

  property p_no_set_halted;
    @(posedge mclk) disable iff (sys_rst) converterHalt && !statusFlag |=> !statusFlag;
  endproperty
  a_no_set_halted: assert property (p_no_set_halted) else $error("status set in halt");

  property p_pin_level;
    @(posedge mclk) disable iff (sys_rst)
      outEnable && statusFlag && !polHigh ##1 $stable(outEnable) |-> alertOe && alertFlag;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("alert pin not driven");

  property p_crit_holds;
    @(posedge mclk) disable iff (sys_rst)
      intMode && aboveCrit && !converterHalt |=> statusFlag;
  endproperty
  a_crit_holds: assert property (p_crit_holds) else $error("alert cleared above limit");
endmodule // tss_register_bank

// [tb/tss_host_model.sv]
// serial bus host model: drives the clock pin and pulls the data line low
`timescale 1ns/1ps
module tss_host_model #(
  parameter logic [6:0] DEV = 7'h1d
) (
  output logic sclOut,
  output logic sdaLow,
  input wire logic sdaLine
);
  localparam int Q = 16; // quarter of the 64 ns bit period
  // bus idle: clock high, data released to the pull-up
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sdaLow = 1'b0;
    #Q sclOut = 1'b1;
    #Q sdaLow = 1'b1;
    #Q sclOut = 1'b0;
  endtask
  // stop, then a bus-free gap before the next start
  task automatic stop();
    sdaLow = 1'b1;
    #Q sclOut = 1'b1;
    #Q sdaLow = 1'b0;
    #(4*Q);
  endtask
  // data changes only while the clock is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic got);
    sdaLow = !b;
    #Q sclOut = 1'b1;
    #Q got = sdaLine;
    #Q sclOut = 1'b0;
    #Q;
  endtask
  // byte out, msb first; ack is the ninth bit
  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(d[i], g);
    bit_io(1'b1, ack);
  endtask
  // byte in; the last byte gets no ack, which ends the read
  task automatic recv(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, g);
  endtask
  // register write: address, pointer, msb, lsb; any missing ack is reported
  task automatic wr(input logic [2:0] p, input logic [15:0] d, output logic nack);
    logic [3:0] a;
    start();
    send({DEV, 1'b0}, a[0]);
    send({5'h00, p}, a[1]);
    send(d[15:8], a[2]);
    send(d[7:0], a[3]);
    stop();
    nack = |a;
  endtask
  // read, selective when sel is set, otherwise from the current pointer
  task automatic rd(input logic sel, input logic [2:0] p, output logic [15:0] d);
    logic a;
    if (sel) begin
      start();
      send({DEV, 1'b0}, a);
      send({5'h00, p}, a);
    end
    start();
    send({DEV, 1'b1}, a);
    recv(1'b0, d[15:8]);
    recv(1'b1, d[7:0]);
    stop();
  endtask
endmodule // tss_host_model

// [tb/tb_top.sv]
// self-checking bench for the thermal sensor register bank
`timescale 1ns/1ps
module tb_top;
  import tss_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [12:0] sampleTemp = 13'h0000;
  logic sampleValid = 1'b0;
  logic scl, hostLow, sdaOut, sdaOe, converterHalt, alertOut, alertOe, nack;
  logic [15:0] v;
  wire logic sdaLine = !(hostLow | sdaOe); // pull-up on the data line
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  always #2 mclk = !mclk;
  // short timeout so a stuck transfer cannot hide in a long count
  tss_register_bank #(.TIMEOUT_CYCLES(200)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(3'h5),
    .sampleTemp(sampleTemp), .sampleValid(sampleValid), .converterHalt(converterHalt),
    .alertOut(alertOut), .alertOe(alertOe));
  tss_host_model #(.DEV(7'h1d)) u_host (.sclOut(scl), .sdaLow(hostLow), .sdaLine(sdaLine));
  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    u_host.wr(p, d, nack);
    chk({15'h0000, nack}, 16'h0000);
  endtask
  task automatic rd(input logic [2:0] p, input logic [15:0] exp);
    u_host.rd(1'b1, p, v);
    chk(v, exp);
  endtask
  // one converter result pulse, then time for trips and alert to settle
  task automatic sample(input logic [12:0] t);
    @(negedge mclk);
    sampleTemp = t;
    sampleValid = 1'b1;
    @(negedge mclk);
    sampleValid = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (10) @(negedge mclk);
  endtask
  task automatic t_reset();
    u_host.rd(1'b0, 3'h0, v);
    chk(v, 16'h0077);
    for (int i = 1; i < 5; i++) rd(3'(i), 16'h0000);
    rd(TSS_PTR_MAKER, 16'h5a5a);
    rd(TSS_PTR_PART, 16'h0101);
  endtask
  task automatic t_write();
    wr(TSS_PTR_FEATURE, 16'hffff);
    rd(TSS_PTR_FEATURE, 16'h0077);
    wr(TSS_PTR_CONTROL, 16'hf820);
    rd(TSS_PTR_CONTROL, 16'h0000);
    wr(TSS_PTR_UPPER, 16'hffff);
    rd(TSS_PTR_UPPER, 16'h1ffc);
    wr(TSS_PTR_TEMP, 16'h1234);
    // upper limit now sits just below zero, so the high trip flag shows
    rd(TSS_PTR_TEMP, 16'h4000);
  endtask
  task automatic t_temp();
    wr(TSS_PTR_UPPER, 16'h0320);
    wr(TSS_PTR_OVERHEAT, 16'h0640);
    sample(13'h0190);
    rd(TSS_PTR_TEMP, 16'h0190);
    sample(13'h1e70);
    rd(TSS_PTR_TEMP, 16'h3e70);
    wr(TSS_PTR_CONTROL, 16'h0100);
    chk({15'h0000, converterHalt}, 16'h0001);
    sample(13'h0320);
    rd(TSS_PTR_TEMP, 16'h3e70);
    wr(TSS_PTR_CONTROL, 16'h0000);
    chk({15'h0000, converterHalt}, 16'h0000);
  endtask
  task automatic t_alert();
    wr(TSS_PTR_CONTROL, 16'h0008);
    sample(13'h0400);
    rd(TSS_PTR_TEMP, 16'h4400);
    rd(TSS_PTR_CONTROL, 16'h0018);
    chk({15'h0000, alertOe}, 16'h0001);
    chk({14'h0000, sdaOut, alertOut}, 16'h0000);
    wr(TSS_PTR_CONTROL, 16'h0028);
    rd(TSS_PTR_CONTROL, 16'h0018);
    wr(TSS_PTR_CONTROL, 16'h000a);
    rd(TSS_PTR_CONTROL, 16'h001a);
    chk({15'h0000, alertOe}, 16'h0000);
    wr(TSS_PTR_CONTROL, 16'h0002);
    rd(TSS_PTR_CONTROL, 16'h0002);
    chk({15'h0000, alertOe}, 16'h0001);
    wr(TSS_PTR_CONTROL, 16'h0009);
    sample(13'h0190);
    rd(TSS_PTR_CONTROL, 16'h0019);
    wr(TSS_PTR_CONTROL, 16'h0029);
    rd(TSS_PTR_CONTROL, 16'h0009);
    // above overheat the clear is held back until the temperature drops
    sample(13'h0700);
    rd(TSS_PTR_TEMP, 16'hc700);
    wr(TSS_PTR_CONTROL, 16'h0029);
    rd(TSS_PTR_CONTROL, 16'h0019);
    sample(13'h0190);
    rd(TSS_PTR_CONTROL, 16'h0009);
  endtask
  // six degree hysteresis keeps the high flag until well below the limit
  task automatic t_trip_hysteresis_select();
    wr(TSS_PTR_CONTROL, 16'h0608);
    sample(13'h0330);
    sample(13'h02f0);
    rd(TSS_PTR_TEMP, 16'h42f0);
    rd(TSS_PTR_CONTROL, 16'h0618);
    wr(TSS_PTR_CONTROL, 16'h060c);
    rd(TSS_PTR_CONTROL, 16'h060c);
  endtask
  // clock held low past the watchdog limit abandons the transfer
  task automatic t_timeout();
    logic a;
    u_host.start();
    u_host.send({7'h1d, 1'b0}, a);
    chk({15'h0000, a}, 16'h0000);
    #1000;
    u_host.send({5'h00, TSS_PTR_UPPER}, a);
    chk({15'h0000, a}, 16'h0001);
    u_host.stop();
  endtask
  task automatic t_lock();
    wr(TSS_PTR_CONTROL, 16'h00c0);
    wr(TSS_PTR_OVERHEAT, 16'h0500);
    rd(TSS_PTR_OVERHEAT, 16'h0640);
    wr(TSS_PTR_UPPER, 16'h0100);
    rd(TSS_PTR_UPPER, 16'h0320);
    wr(TSS_PTR_CONTROL, 16'h070f);
    rd(TSS_PTR_CONTROL, 16'h00c0);
    chk({15'h0000, converterHalt}, 16'h0000);
    do_reset();
    rd(TSS_PTR_CONTROL, 16'h0000);
  endtask
  // hang guard, well above the length of all scenarios
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    do_reset();
    t_reset();
    t_write();
    t_temp();
    t_alert();
    t_trip_hysteresis_select();
    t_lock();
    t_timeout();
    test_done();
  end
endmodule // tb_top
